//--- core/arc_readout_ctrl.sv
`timescale 1ns/1ps
`include "arc_regs.svh"
module arc_readout_ctrl (
  input wire logic CLK,
  input wire logic RST,
  input wire arc_pkg::arc_word_t REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire arc_pkg::arc_word_t REG_WDATA,
  output arc_pkg::arc_word_t REG_RDATA,
  output logic REG_ACK,
  input wire logic FRONT_RESET,
  input wire logic [3:0] BOARD_TYPE,
  input wire logic MODE_AUTO_ADVANCE,
  input wire logic MODE_COUNT_EVERY,
  input wire logic CLEAR_DATA_REQ,
  input wire logic TRIG_PULSE,
  input wire logic TRIG_ACCEPTED,
  input wire logic WORD_IN_VALID,
  input wire arc_pkg::arc_data_t WORD_IN_DATA,
  input wire logic WORD_IN_LAST,
  output logic WORD_IN_READY,
  input wire logic RD_STROBE,
  input wire logic RD_BLOCK,
  output arc_pkg::arc_data_t RD_DATA,
  output logic RD_VALID,
  output logic RD_DTACK,
  output logic RD_BERR,
  output logic [7:0] RELOC_HIGH,
  output logic [7:0] RELOC_LOW,
  output logic CHAIN_FIRST,
  output logic CHAIN_LAST,
  output logic [9:0] FAST_CLEAR_N,
  output logic IRQ_REQ,
  output logic MODULE_RESET,
  output logic DATA_RESET
);
  import arc_pkg::*;

  function automatic logic hit(input arc_word_t a, input arc_word_t off);
    hit = (a == off);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and reset pulses
  logic fr_s1_r, fr_s2_r, fr_s3_r;
  logic [3:0] bt_s1_r, bt_s2_r;
  logic soft_rst_r, data_rst_r;
  logic [`GC_W-1:0] gc_r;
  logic fr_edge;
  assign fr_edge = fr_s2_r & ~fr_s3_r;

  always_ff @(posedge CLK) begin
    if (RST) begin
      fr_s1_r <= 1'b0;
      fr_s2_r <= 1'b0;
      fr_s3_r <= 1'b0;
      bt_s1_r <= 4'h0;
      bt_s2_r <= 4'h0;
    end else begin
      fr_s1_r <= FRONT_RESET;
      fr_s2_r <= fr_s1_r;
      fr_s3_r <= fr_s2_r;
      bt_s1_r <= BOARD_TYPE;
      bt_s2_r <= bt_s1_r;
    end
  end

  logic shot_wr;
  assign shot_wr = REG_WR & hit(REG_ADDR, `ADR_SHOT_RST);

  always_ff @(posedge CLK) begin
    if (RST) begin
      soft_rst_r <= 1'b0;
      data_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= shot_wr | (fr_edge & gc_r[`GC_SCOPE_BIT]);
      data_rst_r <= shot_wr | fr_edge | CLEAR_DATA_REQ;
    end
  end
  assign MODULE_RESET = soft_rst_r;
  assign DATA_RESET = data_rst_r;

  ////////////////////////////////////////////////////////////////////////
  // control registers
  logic [`THR_W-1:0] thr_r;
  logic [`FC_W-1:0] fc_r;
  logic [7:0] rel_hi_r, rel_lo_r;
  logic ch_first_r, ch_last_r;

  always_ff @(posedge CLK) begin
    if (RST) begin
      gc_r <= `GC_RESET;
    end else if (soft_rst_r) begin
      gc_r <= `GC_RESET;
      gc_r[`GC_SCOPE_BIT] <= gc_r[`GC_SCOPE_BIT];
    end else if (REG_WR && hit(REG_ADDR, `ADR_GEN_CTRL)) begin
      gc_r <= REG_WDATA[`GC_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || soft_rst_r) begin
      thr_r <= `THR_RESET;
    end else if (REG_WR && hit(REG_ADDR, `ADR_EVT_THR)) begin
      thr_r <= REG_WDATA[`THR_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      fc_r <= `FC_RESET;
    end else if (REG_WR && hit(REG_ADDR, `ADR_FAST_CLR)) begin
      fc_r <= REG_WDATA[`FC_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rel_hi_r <= 8'h00;
      rel_lo_r <= 8'h00;
      ch_first_r <= 1'b0;
      ch_last_r <= 1'b0;
    end else begin
      if (REG_WR && hit(REG_ADDR, `ADR_RELOC_HI)) begin
        rel_hi_r <= REG_WDATA[7:0];
      end
      if (REG_WR && hit(REG_ADDR, `ADR_RELOC_LO)) begin
        rel_lo_r <= REG_WDATA[7:0];
      end
      if (REG_WR && hit(REG_ADDR, `ADR_CHAIN)) begin
        ch_first_r <= REG_WDATA[`CH_FIRST_BIT];
        ch_last_r <= REG_WDATA[`CH_LAST_BIT];
      end
    end
  end
  assign RELOC_HIGH = rel_hi_r;
  assign RELOC_LOW = rel_lo_r;
  assign CHAIN_FIRST = ch_first_r;
  assign CHAIN_LAST = ch_last_r;
  assign FAST_CLEAR_N = fc_r;

  ////////////////////////////////////////////////////////////////////////
  // event counter
  logic [`EVC_W-1:0] evc_r;
  logic evc_inc, evc_clr;
  assign evc_inc = MODE_COUNT_EVERY ? TRIG_PULSE : TRIG_ACCEPTED;
  assign evc_clr = (REG_WR && hit(REG_ADDR, `ADR_EVC_CLR)) | soft_rst_r |
                   (data_rst_r & ~MODE_COUNT_EVERY);

  always_ff @(posedge CLK) begin
    if (RST) begin
      evc_r <= '0;
    end else if (evc_clr) begin
      evc_r <= {{(`EVC_W-1){1'b0}}, evc_inc};
    end else begin
      evc_r <= evc_r + {{(`EVC_W-1){1'b0}}, evc_inc};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-entry input buffer
  arc_entry_t sk_mem_r [2];
  logic sk_wp_r, sk_rp_r, in_ready_r;
  logic [1:0] sk_cnt_r, sk_cnt_nxt;
  logic sk_push, sk_pop;
  logic [5:0] ob_cnt_r;
  assign sk_push = WORD_IN_VALID & in_ready_r;
  assign sk_pop = (sk_cnt_r != 2'h0) & (ob_cnt_r != `OB_DEPTH);

  always_comb begin
    sk_cnt_nxt = sk_cnt_r;
    if (data_rst_r) begin
      sk_cnt_nxt = 2'h0;
    end else if (sk_push && !sk_pop) begin
      sk_cnt_nxt = sk_cnt_r + 2'h1;
    end else if (sk_pop && !sk_push) begin
      sk_cnt_nxt = sk_cnt_r - 2'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      sk_wp_r <= 1'b0;
      sk_rp_r <= 1'b0;
      sk_cnt_r <= 2'h0;
      in_ready_r <= 1'b0;
    end else begin
      sk_cnt_r <= sk_cnt_nxt;
      in_ready_r <= (sk_cnt_nxt != 2'h2);
      if (data_rst_r) begin
        sk_wp_r <= 1'b0;
        sk_rp_r <= 1'b0;
      end else begin
        if (sk_push) begin
          sk_mem_r[sk_wp_r] <= {WORD_IN_LAST, WORD_IN_DATA};
          sk_wp_r <= ~sk_wp_r;
        end
        if (sk_pop) begin
          sk_rp_r <= ~sk_rp_r;
        end
      end
    end
  end
  assign WORD_IN_READY = in_ready_r;

  ////////////////////////////////////////////////////////////////////////
  // output buffer and read pointer
  arc_entry_t ob_mem_r [`OB_DEPTH];
  logic [`OB_AW-1:0] ob_wp_r, ob_rp_r;
  logic [5:0] evb_r;
  arc_entry_t head, sk_head;
  logic ob_empty, pop, pop_rd, pop_nw, pop_skip;
  arc_ptr_state_t ptr_st_r;
  assign head = ob_mem_r[ob_rp_r];
  assign sk_head = sk_mem_r[sk_rp_r];
  assign ob_empty = (ob_cnt_r == 6'h00);
  assign pop_nw = REG_WR & hit(REG_ADDR, `ADR_NEXT_WORD) & ~ob_empty;
  assign pop_skip = (ptr_st_r == ARC_SKIP) & ~ob_empty;
  assign pop = pop_rd | pop_nw | pop_skip;

  always_ff @(posedge CLK) begin
    if (RST || data_rst_r) begin
      ptr_st_r <= ARC_IDLE;
    end else begin
      case (ptr_st_r)
        ARC_IDLE: begin
          if (REG_WR && hit(REG_ADDR, `ADR_NEXT_EVT)) begin
            ptr_st_r <= ARC_SKIP;
          end
        end
        ARC_SKIP: begin
          if (ob_empty || (pop && head[32])) begin
            ptr_st_r <= ARC_IDLE;
          end
        end
        default: ptr_st_r <= ARC_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || data_rst_r) begin
      ob_wp_r <= '0;
      ob_rp_r <= '0;
      ob_cnt_r <= 6'h00;
      evb_r <= 6'h00;
    end else begin
      if (sk_pop) begin
        ob_mem_r[ob_wp_r] <= sk_head;
        ob_wp_r <= ob_wp_r + 1'b1;
      end
      if (pop) begin
        ob_rp_r <= ob_rp_r + 1'b1;
      end
      ob_cnt_r <= ob_cnt_r + {5'h00, sk_pop} - {5'h00, pop};
      evb_r <= evb_r + {5'h00, sk_pop & sk_head[32]} -
               {5'h00, pop & head[32]};
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      IRQ_REQ <= 1'b0;
    end else begin
      IRQ_REQ <= (thr_r != `THR_RESET) && (evb_r == {1'b0, thr_r});
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data readout
  logic blk_done_r, evt_odd_r, filler_r;
  logic stop_m, berr_m, align_m, rd_norm, rd_last;
  assign stop_m = gc_r[`GC_STOP_BIT];
  assign berr_m = gc_r[`GC_BERR_BIT];
  assign align_m = gc_r[`GC_ALIGN_BIT];
  assign rd_norm = RD_STROBE & ~filler_r & ~ob_empty & ~blk_done_r;
  assign rd_last = rd_norm & head[32];
  assign pop_rd = rd_norm & MODE_AUTO_ADVANCE;

  always_ff @(posedge CLK) begin
    if (RST || data_rst_r) begin
      RD_DATA <= '0;
      RD_VALID <= 1'b0;
      RD_DTACK <= 1'b0;
      RD_BERR <= 1'b0;
    end else begin
      RD_VALID <= 1'b0;
      RD_DTACK <= 1'b0;
      RD_BERR <= 1'b0;
      if (RD_STROBE && filler_r) begin
        RD_DATA <= `FILLER_WORD;
        RD_DTACK <= 1'b1;
      end else if (rd_norm) begin
        RD_DATA <= head[31:0];
        RD_VALID <= 1'b1;
        if (RD_BLOCK && berr_m &&
            (stop_m ? head[32] : (ob_cnt_r == 6'h01))) begin
          RD_BERR <= 1'b1;
        end else begin
          RD_DTACK <= 1'b1;
        end
      end else if (RD_STROBE) begin
        RD_DATA <= '0;
        RD_BERR <= RD_BLOCK & berr_m;
        RD_DTACK <= ~(RD_BLOCK & berr_m);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || data_rst_r || !RD_BLOCK) begin
      blk_done_r <= 1'b0;
      evt_odd_r <= 1'b0;
      filler_r <= 1'b0;
    end else begin
      if (rd_last && stop_m) begin
        blk_done_r <= 1'b1;
      end
      if (rd_last) begin
        evt_odd_r <= 1'b0;
        filler_r <= align_m & ~evt_odd_r;
      end else if (rd_norm) begin
        evt_odd_r <= ~evt_odd_r;
      end else if (RD_STROBE) begin
        filler_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read port
  arc_word_t rdata;
  always_comb begin
    rdata = 16'h0000;
    case (REG_ADDR)
      `ADR_GEN_CTRL: rdata = {9'h000, gc_r};
      `ADR_RELOC_HI: rdata = {8'h00, rel_hi_r};
      `ADR_RELOC_LO: rdata = {8'h00, rel_lo_r};
      `ADR_EVT_THR: rdata = {11'h000, thr_r};
      `ADR_FAST_CLR: rdata = {6'h00, fc_r};
      `ADR_STATUS: begin
        rdata[`ST_EMPTY_BIT] = ob_empty;
        rdata[`ST_FULL_BIT] = (ob_cnt_r == `OB_DEPTH);
        rdata[`ST_TYPE_LSB+3:`ST_TYPE_LSB] = bt_s2_r;
      end
      `ADR_EVC_LO: rdata = evc_r[15:0];
      `ADR_EVC_HI: rdata = {8'h00, evc_r[23:16]};
      default: rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      REG_RDATA <= 16'h0000;
      REG_ACK <= 1'b0;
    end else begin
      REG_RDATA <= REG_RD ? rdata : 16'h0000;
      REG_ACK <= REG_RD | REG_WR;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  irq_match_a: assert property (
    (thr_r != 5'h00 && evb_r == {1'b0, thr_r}) |=> IRQ_REQ)
    else $error("threshold match raised no request");
  irq_zero_a: assert property (
    IRQ_REQ |-> $past(thr_r) != 5'h00)
    else $error("request with zero threshold");
  berr_empty_a: assert property (
    (RD_STROBE && RD_BLOCK && berr_m && ob_empty && !filler_r &&
     !data_rst_r) |=> (RD_BERR && !RD_DTACK && !RD_VALID))
    else $error("empty block read did not end in bus error");
  dtack_only_a: assert property (
    (RD_STROBE && !berr_m && !data_rst_r) |=> (RD_DTACK && !RD_BERR))
    else $error("read without bus error enable not acknowledged");
  stop_done_a: assert property (
    (rd_last && RD_BLOCK && stop_m && !data_rst_r) |=>
    (blk_done_r || !RD_BLOCK) ##0 RD_VALID)
    else $error("stop mode did not end block at event end");
  align_fill_a: assert property (
    (rd_last && RD_BLOCK && align_m && !evt_odd_r && !data_rst_r)
    |=> (filler_r || !RD_BLOCK))
    else $error("odd event got no filler");
  scope_hold_a: assert property (
    soft_rst_r |=> (gc_r[`GC_SCOPE_BIT] == $past(gc_r[`GC_SCOPE_BIT]) &&
    gc_r[3:0] == 4'h0 && gc_r[6:5] == 2'h0))
    else $error("soft reset mishandled control register");
  evc_clear_a: assert property (
    (REG_WR && REG_ADDR == `ADR_EVC_CLR && !evc_inc) |=> evc_r == '0)
    else $error("counter clear write ignored");
  front_scope_a: assert property (
    (fr_edge && !gc_r[`GC_SCOPE_BIT] && !shot_wr) |=>
    (data_rst_r && !soft_rst_r))
    else $error("front reset scope wrong");
  in_ready_a: assert property (
    (sk_cnt_r == 2'h2) |-> !in_ready_r)
    else $error("input ready while buffer full");

  fill_c: cover property (ob_cnt_r == `OB_DEPTH);
  berr_c: cover property (RD_BLOCK && RD_BERR);
  filler_c: cover property (RD_STROBE && filler_r);
  skip_c: cover property (ptr_st_r == ARC_SKIP ##1 ptr_st_r == ARC_IDLE);
endmodule : arc_readout_ctrl

//--- core/arc_regs.svh
`ifndef ARC_REGS_SVH
`define ARC_REGS_SVH
`define ADR_GEN_CTRL 16'h1010
`define ADR_RELOC_HI 16'h1012
`define ADR_RELOC_LO 16'h1014
`define ADR_SHOT_RST 16'h1016
`define ADR_CHAIN 16'h101A
`define ADR_EVT_THR 16'h1020
`define ADR_STATUS 16'h1022
`define ADR_EVC_LO 16'h1024
`define ADR_EVC_HI 16'h1026
`define ADR_NEXT_EVT 16'h1028
`define ADR_NEXT_WORD 16'h102A
`define ADR_FAST_CLR 16'h102E
`define ADR_EVC_CLR 16'h1040
`define GC_W 7
`define GC_STOP_BIT 2
`define GC_SCOPE_BIT 4
`define GC_BERR_BIT 5
`define GC_ALIGN_BIT 6
`define GC_RESET 7'h00
`define CH_LAST_BIT 0
`define CH_FIRST_BIT 1
`define THR_W 5
`define THR_RESET 5'h00
`define EVC_W 24
`define FC_W 10
`define FC_RESET 10'h000
`define FC_MAX 10'h3F0
`define ST_EMPTY_BIT 0
`define ST_FULL_BIT 1
`define ST_TYPE_LSB 4
`define OB_DEPTH 6'h20
`define OB_AW 5
`define FILLER_WORD 32'h06000000
`endif

//--- core/arc_pkg.sv
package arc_pkg;
  typedef logic [15:0] arc_word_t;
  typedef logic [31:0] arc_data_t;
  typedef logic [32:0] arc_entry_t;
  typedef enum {ARC_IDLE, ARC_SKIP} arc_ptr_state_t;
endpackage : arc_pkg

//--- test/arc_master_model.sv
`timescale 1ns/1ps
`include "arc_regs.svh"
module arc_master_model (
  input wire logic CLK,
  input wire logic REG_ACK,
  input wire arc_pkg::arc_word_t REG_RDATA,
  input wire arc_pkg::arc_data_t RD_DATA,
  input wire logic RD_VALID,
  input wire logic RD_DTACK,
  input wire logic RD_BERR,
  output arc_pkg::arc_word_t REG_ADDR,
  output arc_pkg::arc_word_t REG_WDATA,
  output logic REG_WR,
  output logic REG_RD,
  output logic RD_STROBE
);
  import arc_pkg::*;
  // extra idle edges before each request, for a slow master
  int idle = 0;
  initial begin
    REG_ADDR = 16'h0000;
    REG_WDATA = 16'h0000;
    REG_WR = 1'h0;
    REG_RD = 1'h0;
    RD_STROBE = 1'h0;
  end
  ////////////////////////////////////////////////////////////
  task automatic bus(input arc_word_t a, input arc_word_t v, input logic w,
                     output arc_word_t q, output logic ok);
    repeat (idle + 1) @(posedge CLK);
    #1;
    if (w && a == `ADR_FAST_CLR && v > {6'h00, `FC_MAX}) v = {6'h00, `FC_MAX};
    REG_ADDR = a;
    REG_WDATA = v;
    REG_WR = w;
    REG_RD = ~w;
    @(posedge CLK);
    #1;
    REG_WR = 1'h0;
    REG_RD = 1'h0;
    REG_ADDR = ~a;
    REG_WDATA = ~v;
    ok = 1'h0;
    q = 16'h0000;
    for (int i = 0; i < 4 && ok !== 1'h1; i++) begin
      if (REG_ACK === 1'h1) begin
        ok = 1'h1;
        q = REG_RDATA;
      end else begin
        @(posedge CLK);
        #1;
      end
    end
  endtask : bus
  task automatic dread(output arc_data_t q, output logic [2:0] f);
    repeat (idle + 1) @(posedge CLK);
    #1;
    RD_STROBE = 1'h1;
    @(posedge CLK);
    #1;
    RD_STROBE = 1'h0;
    q = RD_DATA;
    f = {RD_VALID, RD_DTACK, RD_BERR};
  endtask : dread
endmodule : arc_master_model

//--- test/arc_readout_ctrl_tb.sv
`timescale 1ns/1ps
`include "arc_regs.svh"
module arc_readout_ctrl_tb;
  import arc_pkg::*;
  logic CLK = 1'h0;
  logic RST, REG_WR, REG_RD, REG_ACK, WORD_IN_READY, ok;
  arc_word_t REG_ADDR, REG_WDATA, REG_RDATA, q;
  logic FRONT_RESET = 1'h0;
  logic [3:0] BOARD_TYPE = 4'h5;
  logic MODE_AUTO_ADVANCE = 1'h1;
  logic MODE_COUNT_EVERY = 1'h1;
  logic CLEAR_DATA_REQ = 1'h0;
  logic TRIG_PULSE = 1'h0;
  logic TRIG_ACCEPTED = 1'h0;
  logic WORD_IN_VALID = 1'h0;
  logic WORD_IN_LAST = 1'h0;
  logic RD_BLOCK = 1'h0;
  arc_data_t WORD_IN_DATA = 32'h0000_0000;
  arc_data_t RD_DATA, rq;
  logic RD_STROBE, RD_VALID, RD_DTACK, RD_BERR, CHAIN_FIRST, CHAIN_LAST;
  logic [7:0] RELOC_HIGH, RELOC_LOW;
  logic [9:0] FAST_CLEAR_N;
  logic IRQ_REQ, MODULE_RESET, DATA_RESET;
  logic [2:0] rf;
  int failures = 0;
  int n_tests = 0;
  int k, m, d;
  // address, write data, expected readback
  logic [47:0] rows [8] = '{
    {`ADR_GEN_CTRL, 16'hFFFF, 16'h007F}, {`ADR_RELOC_HI, 16'h12A5, 16'h00A5},
    {`ADR_RELOC_LO, 16'h345A, 16'h005A}, {`ADR_EVT_THR, 16'hFFE2, 16'h0002},
    {`ADR_FAST_CLR, 16'h03F0, 16'h03F0}, {`ADR_STATUS, 16'hFFFF, 16'h0051},
    {`ADR_CHAIN, 16'h0003, 16'h0000}, {16'h1030, 16'h1234, 16'h0000}};
  always #20 CLK = ~CLK;
  arc_readout_ctrl i_dut (.CLK, .RST, .REG_ADDR, .REG_WR, .REG_RD,
    .REG_WDATA, .REG_RDATA, .REG_ACK, .FRONT_RESET, .BOARD_TYPE,
    .MODE_AUTO_ADVANCE, .MODE_COUNT_EVERY, .CLEAR_DATA_REQ, .TRIG_PULSE,
    .TRIG_ACCEPTED, .WORD_IN_VALID, .WORD_IN_DATA, .WORD_IN_LAST,
    .WORD_IN_READY, .RD_STROBE, .RD_BLOCK, .RD_DATA, .RD_VALID, .RD_DTACK,
    .RD_BERR, .RELOC_HIGH, .RELOC_LOW, .CHAIN_FIRST, .CHAIN_LAST,
    .FAST_CLEAR_N, .IRQ_REQ, .MODULE_RESET, .DATA_RESET);
  arc_master_model i_m (.CLK, .REG_ACK, .REG_RDATA, .RD_DATA, .RD_VALID,
    .RD_DTACK, .RD_BERR, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
    .RD_STROBE);
  ////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (failures == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input arc_word_t a, input arc_word_t v, input logic w);
    i_m.bus(a, v, w, q, ok);
    chk(ok, 1);
    if (ok !== 1'h1) end_sim();
  endtask : acc
  task automatic rr(input arc_word_t a, input arc_word_t e);
    acc(a, 16'h0000, 1'h0);
    chk(q, e);
  endtask : rr
  task automatic dr(input arc_data_t e, input logic [2:0] ef);
    i_m.dread(rq, rf);
    chk(rq, e);
    chk(rf, ef);
  endtask : dr
  // one-cycle pulse on {trigger, accepted, data clear}
  task automatic pul(input logic [2:0] s);
    @(posedge CLK);
    #1;
    {TRIG_PULSE, TRIG_ACCEPTED, CLEAR_DATA_REQ} = s;
    @(posedge CLK);
    #1;
    {TRIG_PULSE, TRIG_ACCEPTED, CLEAR_DATA_REQ} = 3'h0;
  endtask : pul
  task automatic hrst;
    RST = 1'h1;
    repeat (3) @(posedge CLK);
    #1;
    RST = 1'h0;
  endtask : hrst
  // count reset pulses seen after a front reset edge
  task automatic fr;
    m = 0;
    d = 0;
    @(posedge CLK);
    #1;
    FRONT_RESET = 1'h1;
    repeat (10) begin
      @(posedge CLK);
      #1;
      m += (MODULE_RESET === 1'h1);
      d += (DATA_RESET === 1'h1);
    end
    FRONT_RESET = 1'h0;
    repeat (3) @(posedge CLK);
    #1;
  endtask : fr
  task automatic push(input arc_data_t v, input logic l, input logic must);
    @(posedge CLK);
    #1;
    WORD_IN_DATA = v;
    WORD_IN_LAST = l;
    WORD_IN_VALID = 1'h1;
    ok = 1'h0;
    for (int i = 0; i < 40 && ok !== 1'h1; i++) begin
      ok = WORD_IN_READY;
      @(posedge CLK);
      #1;
    end
    WORD_IN_VALID = 1'h0;
    WORD_IN_DATA = ~v;
    WORD_IN_LAST = ~l;
    if (must) begin
      chk(ok, 1);
      if (ok !== 1'h1) end_sim();
    end
  endtask : push
  ////////////////////////////////////////////////////////////
  initial begin
    hrst();
    chk(IRQ_REQ, 0);
    rr(`ADR_GEN_CTRL, 16'h0000);
    rr(`ADR_EVT_THR, 16'h0000);
    rr(`ADR_STATUS, 16'h0051);
    foreach (rows[i]) begin
      acc(rows[i][47:32], rows[i][31:16], 1'h1);
      rr(rows[i][47:32], rows[i][15:0]);
    end
    chk({RELOC_HIGH, RELOC_LOW}, 32'hA55A);
    chk(FAST_CLEAR_N, 32'h3F0);
    for (k = 0; k < 4; k++) begin
      acc(`ADR_CHAIN, 16'hFFFC | k[15:0], 1'h1);
      chk({CHAIN_FIRST, CHAIN_LAST}, k);
    end
    pul(3'h4);
    pul(3'h4);
    pul(3'h6);
    rr(`ADR_EVC_LO, 16'h0003);
    rr(`ADR_EVC_HI, 16'h0000);
    MODE_COUNT_EVERY = 1'h0;
    pul(3'h6);
    pul(3'h4);
    rr(`ADR_EVC_LO, 16'h0004);
    pul(3'h1);
    rr(`ADR_EVC_LO, 16'h0000);
    MODE_COUNT_EVERY = 1'h1;
    pul(3'h4);
    pul(3'h1);
    rr(`ADR_EVC_LO, 16'h0001);
    acc(`ADR_EVC_CLR, 16'h5A5A, 1'h1);
    rr(`ADR_EVC_LO, 16'h0000);
    pul(3'h4);
    acc(`ADR_SHOT_RST, 16'h0000, 1'h1);
    rr(`ADR_EVC_LO, 16'h0000);
    rr(`ADR_GEN_CTRL, 16'h0010);
    rr(`ADR_EVT_THR, 16'h0000);
    fr();
    chk(m, 1);
    chk(d != 0, 1);
    rr(`ADR_GEN_CTRL, 16'h0010);
    hrst();
    rr(`ADR_GEN_CTRL, 16'h0000);
    fr();
    chk(m, 0);
    chk(d != 0, 1);
    push(32'h0000_0001, 1'h1, 1'h1);
    pul(3'h1);
    rr(`ADR_STATUS, 16'h0051);
    acc(`ADR_EVT_THR, 16'h0003, 1'h1);
    i_m.idle = 2;
    for (k = 0; k < 6; k++) push(32'h00AB_0000 + k, k == 1 || k >= 4, 1'h1);
    repeat (4) @(posedge CLK);
    #1;
    chk(IRQ_REQ, 1);
    rr(`ADR_STATUS, 16'h0050);
    dr(32'h00AB_0000, 3'h6);
    dr(32'h00AB_0001, 3'h6);
    rr(`ADR_STATUS, 16'h0050);
    chk(IRQ_REQ, 0);
    MODE_AUTO_ADVANCE = 1'h0;
    dr(32'h00AB_0002, 3'h6);
    dr(32'h00AB_0002, 3'h6);
    acc(`ADR_NEXT_WORD, 16'h0000, 1'h1);
    dr(32'h00AB_0003, 3'h6);
    acc(`ADR_NEXT_EVT, 16'h0000, 1'h1);
    dr(32'h00AB_0005, 3'h6);
    MODE_AUTO_ADVANCE = 1'h1;
    dr(32'h00AB_0005, 3'h6);
    dr(32'h0000_0000, 3'h2);
    i_m.idle = 0;
    RD_BLOCK = 1'h1;
    acc(`ADR_GEN_CTRL, 16'h0024, 1'h1);
    for (k = 0; k < 3; k++) push(32'h00CD_0000 + k, k > 0, 1'h1);
    dr(32'h00CD_0000, 3'h6);
    dr(32'h00CD_0001, 3'h5);
    dr(32'h0000_0000, 3'h1);
    RD_BLOCK = 1'h0;
    acc(`ADR_GEN_CTRL, 16'h0020, 1'h1);
    RD_BLOCK = 1'h1;
    dr(32'h00CD_0002, 3'h5);
    dr(32'h0000_0000, 3'h1);
    acc(`ADR_GEN_CTRL, 16'h0000, 1'h1);
    dr(32'h0000_0000, 3'h2);
    acc(`ADR_GEN_CTRL, 16'h0040, 1'h1);
    for (k = 0; k < 5; k++) push(32'h00EF_0000 + k, k == 2 || k == 4, 1'h1);
    for (k = 0; k < 3; k++) dr(32'h00EF_0000 + k, 3'h6);
    dr(`FILLER_WORD, 3'h2);
    dr(32'h00EF_0003, 3'h6);
    dr(32'h00EF_0004, 3'h6);
    dr(32'h0000_0000, 3'h2);
    RD_BLOCK = 1'h0;
    for (k = 0; k < 40; k++) begin
      push(32'h00F0_0000 + k, 1'h1, 1'h0);
      if (ok !== 1'h1) break;
    end
    chk(k, 34);
    rr(`ADR_STATUS, 16'h0052);
    for (k = 0; k < 34; k++) dr(32'h00F0_0000 + k, 3'h6);
    rr(`ADR_STATUS, 16'h0051);
    end_sim();
  end
endmodule : arc_readout_ctrl_tb
